// File: hdl/cvp_map.svh
// Register offsets, field positions and reset values of the video capture port
// How it works
// - Pixel clock strobes all sixteen data lines
// - Write gate pin gates stored samples
// - Field pin tags which field arrives
// - One- or two-field sensors handled in hardware
// - Frame sync: input slave, output master
// - Line sync: input slave, output master
// - Raw: lower 0-7, upper 0-5 form 14 bits
// - Raw: upper lines 6 and 7 ignored
// - YCC16: luma from lower lines
// - YCC16: alternating Cb/Cr from upper lines
// - YCC8: lower lines carry channel one
// - YCC8: upper lines carry independent channel two
`ifndef CVP_MAP_SVH
`define CVP_MAP_SVH

`define CVP_OFS_CTRL       8'h00
`define CVP_OFS_LINE_LEN   8'h04
`define CVP_OFS_FRAME_LEN  8'h08
`define CVP_OFS_STATUS     8'h0C
`define CVP_OFS_PIXEL      8'h10

`define CVP_CTRL_EN        0
`define CVP_CTRL_MODE_LO   1
`define CVP_CTRL_MODE_HI   2
`define CVP_CTRL_MASTER    3
`define CVP_CTRL_FIELD_SEL 4
`define CVP_CTRL_TWO_FIELD 5

`define CVP_RST_LINE_LEN   16'h0010
`define CVP_RST_FRAME_LEN  16'h0008

`endif

// File: hdl/cvp_pkg.sv
// Types shared by the video capture port
`default_nettype none
package cvp_pkg;

	typedef enum logic [1:0] {
		CVP_RAW14 = 2'b00,
		CVP_YCC16 = 2'b01,
		CVP_YCC8  = 2'b10
	} cvp_mode_t;

	typedef enum logic [1:0] {
		CVP_COMP_Y   = 2'b00,
		CVP_COMP_CB  = 2'b01,
		CVP_COMP_CR  = 2'b10,
		CVP_COMP_RAW = 2'b11
	} cvp_comp_t;

	typedef struct packed {
		logic        enable;
		cvp_mode_t   mode;
		logic        master;
		logic        field_sel;
		logic        two_field;
		logic [15:0] line_len;
		logic [15:0] frame_len;
	} cvp_cfg_t;

	typedef struct packed {
		logic [15:0] data;
		cvp_comp_t   comp_lo;
		cvp_comp_t   comp_hi;
		logic        field;
		logic        sol;
		logic        sof;
	} cvp_pix_t;

endpackage
`default_nettype wire

// File: hdl/cvp_capture.sv
// Parallel video capture port: pixel-clock front end plus register port
//
// Chosen here: the placing of the registers and strobed register access.
`include "cvp_map.svh"
`default_nettype none
module cvp_capture
	import cvp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        pixel_clk,
	input  wire logic [7:0]  lower_video_data,
	input  wire logic [7:0]  upper_video_data,
	input  wire logic        write_gate_or_field_id,
	input  wire logic        frame_sync_in,
	output logic             frame_sync_out,
	output logic             frame_sync_oe,
	input  wire logic        line_sync_in,
	output logic             line_sync_out,
	output logic             line_sync_oe,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic             pix_valid,
	output cvp_pix_t         pix_out
);

	localparam cvp_cfg_t CFG_RESET = '{
		enable: 1'b0, mode: CVP_RAW14, master: 1'b0, field_sel: 1'b0,
		two_field: 1'b0, line_len: `CVP_RST_LINE_LEN, frame_len: `CVP_RST_FRAME_LEN};

	function automatic cvp_comp_t comp_of_phase(input logic [1:0] ph);
		unique case (ph)
			2'b00: comp_of_phase = CVP_COMP_CB;
			2'b01: comp_of_phase = CVP_COMP_Y;
			2'b10: comp_of_phase = CVP_COMP_CR;
			2'b11: comp_of_phase = CVP_COMP_Y;
		endcase
	endfunction

	// ---- System clock side: registers and configuration launch
	cvp_cfg_t    cfg_reg;
	cvp_cfg_t    cfg_hold_reg;
	logic        dirty_reg;
	logic        req_reg;
	logic        ack_meta_reg;
	logic        ack_sync_reg;
	logic        busy;
	logic        launch;
	logic        cfg_write;
	logic        tgl_meta_reg;
	logic        tgl_sync_reg;
	logic        tgl_prev_reg;
	logic        new_pix;
	logic [15:0] frame_cnt_reg;
	logic [31:0] rdata_reg;
	logic        pix_valid_reg;
	cvp_pix_t    pix_out_reg;

	// ---- Pixel clock side
	logic        prst_meta_reg;
	logic        prst_reg;
	logic        req_meta_reg;
	logic        req_sync_reg;
	logic        req_seen_reg;
	cvp_cfg_t    pcfg_reg;
	logic [18:0] pin_meta_reg;
	logic [18:0] pin_sync_reg;
	logic        fs_prev_reg;
	logic        ls_prev_reg;
	logic [7:0]  lo_s;
	logic [7:0]  hi_s;
	logic        ls_s;
	logic        fs_s;
	logic        wf_s;
	logic [15:0] h_cnt_reg;
	logic [15:0] v_cnt_reg;
	logic        run_master;
	logic        line_start;
	logic        frame_start;
	logic        restart;
	logic        field_reg;
	logic        field_now;
	logic        cap;
	logic        cph_reg;
	logic [1:0]  ph_lo_reg;
	logic [1:0]  ph_hi_reg;
	logic        cur_c;
	logic [1:0]  cur_lo;
	logic [1:0]  cur_hi;
	cvp_pix_t    pix_next;
	cvp_pix_t    pix_hold_reg;
	logic        pix_tgl_reg;

	assign cfg_write = reg_wr && (reg_addr == `CVP_OFS_CTRL || reg_addr == `CVP_OFS_LINE_LEN
		|| reg_addr == `CVP_OFS_FRAME_LEN);
	assign busy      = req_reg != ack_sync_reg;
	assign launch    = dirty_reg && !busy;

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg <= CFG_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`CVP_OFS_CTRL: begin
					cfg_reg.enable    <= reg_wdata[`CVP_CTRL_EN];
					cfg_reg.mode      <= cvp_mode_t'(reg_wdata[`CVP_CTRL_MODE_HI:`CVP_CTRL_MODE_LO]);
					cfg_reg.master    <= reg_wdata[`CVP_CTRL_MASTER];
					cfg_reg.field_sel <= reg_wdata[`CVP_CTRL_FIELD_SEL];
					cfg_reg.two_field <= reg_wdata[`CVP_CTRL_TWO_FIELD];
				end
				`CVP_OFS_LINE_LEN:  cfg_reg.line_len  <= reg_wdata[15:0];
				`CVP_OFS_FRAME_LEN: cfg_reg.frame_len <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// A write in the launch cycle keeps the dirty mark, so no setting is lost
	always_ff @(posedge clk) begin
		if (rst) begin
			dirty_reg    <= 1'b0;
			req_reg      <= 1'b0;
			cfg_hold_reg <= CFG_RESET;
		end else begin
			if (cfg_write) begin
				dirty_reg <= 1'b1;
			end else if (launch) begin
				dirty_reg <= 1'b0;
			end
			if (launch) begin
				cfg_hold_reg <= cfg_reg;
				req_reg      <= ~req_reg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
			tgl_meta_reg <= 1'b0;
			tgl_sync_reg <= 1'b0;
			tgl_prev_reg <= 1'b0;
		end else begin
			ack_meta_reg <= req_seen_reg;
			ack_sync_reg <= ack_meta_reg;
			tgl_meta_reg <= pix_tgl_reg;
			tgl_sync_reg <= tgl_meta_reg;
			tgl_prev_reg <= tgl_sync_reg;
		end
	end

	assign new_pix = tgl_sync_reg ^ tgl_prev_reg;

	// Hold register is stable for a whole pixel period, far longer than the sync delay
	always_ff @(posedge clk) begin
		if (rst) begin
			pix_out_reg   <= '0;
			pix_valid_reg <= 1'b0;
			frame_cnt_reg <= 16'h0000;
		end else begin
			pix_valid_reg <= new_pix;
			if (new_pix) begin
				pix_out_reg <= pix_hold_reg;
				if (pix_hold_reg.sof) begin
					frame_cnt_reg <= frame_cnt_reg + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !reg_rd) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			unique case (reg_addr)
				`CVP_OFS_CTRL:      rdata_reg <= {26'h0000000, cfg_reg.two_field,
					cfg_reg.field_sel, cfg_reg.master, cfg_reg.mode, cfg_reg.enable};
				`CVP_OFS_LINE_LEN:  rdata_reg <= {16'h0000, cfg_reg.line_len};
				`CVP_OFS_FRAME_LEN: rdata_reg <= {16'h0000, cfg_reg.frame_len};
				`CVP_OFS_STATUS:    rdata_reg <= {frame_cnt_reg, 13'h0000,
					dirty_reg || busy, pix_out_reg.field, pix_out_reg.sof};
				`CVP_OFS_PIXEL:     rdata_reg <= {16'h0000, pix_out_reg.data};
				default:            rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign reg_rdata = rdata_reg;
	assign pix_valid = pix_valid_reg;
	assign pix_out   = pix_out_reg;

	// ---- Pixel clock domain
	always_ff @(posedge pixel_clk) begin
		prst_meta_reg <= rst;
		prst_reg      <= prst_meta_reg;
	end

	always_ff @(posedge pixel_clk) begin
		if (prst_reg) begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
			req_seen_reg <= 1'b0;
			pcfg_reg     <= CFG_RESET;
		end else begin
			req_meta_reg <= req_reg;
			req_sync_reg <= req_meta_reg;
			req_seen_reg <= req_sync_reg;
			if (req_sync_reg != req_seen_reg) begin
				pcfg_reg <= cfg_hold_reg;
			end
		end
	end

	// All pins are taken on the pixel strobe through the same two stages, so they stay aligned
	always_ff @(posedge pixel_clk) begin
		pin_meta_reg <= {write_gate_or_field_id, frame_sync_in, line_sync_in,
			upper_video_data, lower_video_data};
		pin_sync_reg <= pin_meta_reg;
		fs_prev_reg  <= pin_sync_reg[17];
		ls_prev_reg  <= pin_sync_reg[16];
	end

	assign lo_s = pin_sync_reg[7:0];
	assign hi_s = pin_sync_reg[15:8];
	assign ls_s = pin_sync_reg[16];
	assign fs_s = pin_sync_reg[17];
	assign wf_s = pin_sync_reg[18];

	assign run_master = pcfg_reg.enable && pcfg_reg.master;

	// Line and frame lengths below two pixels are not supported
	always_ff @(posedge pixel_clk) begin
		if (prst_reg || !run_master) begin
			h_cnt_reg <= 16'h0000;
			v_cnt_reg <= 16'h0000;
		end else if (h_cnt_reg == pcfg_reg.line_len - 16'h0001) begin
			h_cnt_reg <= 16'h0000;
			if (v_cnt_reg == pcfg_reg.frame_len - 16'h0001) begin
				v_cnt_reg <= 16'h0000;
			end else begin
				v_cnt_reg <= v_cnt_reg + 16'h0001;
			end
		end else begin
			h_cnt_reg <= h_cnt_reg + 16'h0001;
		end
	end

	assign line_sync_oe   = pcfg_reg.master;
	assign frame_sync_oe  = pcfg_reg.master;
	assign line_sync_out  = run_master && h_cnt_reg == 16'h0000;
	assign frame_sync_out = run_master && v_cnt_reg == 16'h0000;

	assign line_start  = run_master ? h_cnt_reg == 16'h0000 : ls_s && !ls_prev_reg;
	assign frame_start = run_master ? (h_cnt_reg == 16'h0000 && v_cnt_reg == 16'h0000)
		: fs_s && !fs_prev_reg;
	assign restart = line_start || frame_start;

	always_comb begin
		field_now = field_reg;
		if (frame_start) begin
			if (pcfg_reg.field_sel) begin
				field_now = wf_s;
			end else if (pcfg_reg.two_field) begin
				field_now = ~field_reg;
			end else begin
				field_now = 1'b0;
			end
		end
	end

	always_ff @(posedge pixel_clk) begin
		if (prst_reg) begin
			field_reg <= 1'b0;
		end else if (pcfg_reg.enable) begin
			field_reg <= field_now;
		end
	end

	assign cap    = pcfg_reg.enable && (pcfg_reg.field_sel || wf_s);
	assign cur_c  = restart ? 1'b0 : cph_reg;
	assign cur_lo = restart ? 2'b00 : ph_lo_reg;
	assign cur_hi = restart ? 2'b00 : ph_hi_reg;

	always_ff @(posedge pixel_clk) begin
		if (prst_reg) begin
			cph_reg   <= 1'b0;
			ph_lo_reg <= 2'b00;
			ph_hi_reg <= 2'b00;
		end else if (cap) begin
			cph_reg   <= ~cur_c;
			ph_lo_reg <= cur_lo + 2'b01;
			ph_hi_reg <= cur_hi + 2'b01;
		end
	end

	always_comb begin
		pix_next.field = field_now;
		pix_next.sol   = restart;
		pix_next.sof   = frame_start;
		unique case (pcfg_reg.mode)
			CVP_YCC16: begin
				pix_next.data    = {hi_s, lo_s};
				pix_next.comp_lo = CVP_COMP_Y;
				pix_next.comp_hi = cur_c ? CVP_COMP_CR : CVP_COMP_CB;
			end
			CVP_YCC8: begin
				pix_next.data    = {hi_s, lo_s};
				pix_next.comp_lo = comp_of_phase(cur_lo);
				pix_next.comp_hi = comp_of_phase(cur_hi);
			end
			default: begin
				pix_next.data    = {2'b00, hi_s[5:0], lo_s};
				pix_next.comp_lo = CVP_COMP_RAW;
				pix_next.comp_hi = CVP_COMP_RAW;
			end
		endcase
	end

	always_ff @(posedge pixel_clk) begin
		if (prst_reg) begin
			pix_hold_reg <= '0;
			pix_tgl_reg  <= 1'b0;
		end else if (cap) begin
			pix_hold_reg <= pix_next;
			pix_tgl_reg  <= ~pix_tgl_reg;
		end
	end

	// ---- Assertions
	raw_bits_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && pcfg_reg.mode == CVP_RAW14 |=>
		pix_hold_reg.data[13:0] == {$past(hi_s[5:0]), $past(lo_s)})
		else $error("raw sample bits misplaced");
	raw_top_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && pcfg_reg.mode == CVP_RAW14 |=> pix_hold_reg.data[15:14] == 2'b00)
		else $error("raw sample carries upper lines 6 or 7");
	luma_lower_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && pcfg_reg.mode == CVP_YCC16 |=>
		pix_hold_reg.data[7:0] == $past(lo_s) && pix_hold_reg.comp_lo == CVP_COMP_Y)
		else $error("luma not from lower lines");
	chroma_alt_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && !restart && pcfg_reg.mode == CVP_YCC16 ##1 cap && !restart
		&& pcfg_reg.mode == CVP_YCC16 |=> pix_hold_reg.comp_hi != $past(pix_hold_reg.comp_hi))
		else $error("chroma does not alternate");
	dual_data_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && pcfg_reg.mode == CVP_YCC8 |=> pix_hold_reg.data == {$past(hi_s), $past(lo_s)})
		else $error("dual channel data misplaced");
	dual_phase_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && restart && pcfg_reg.mode == CVP_YCC8 ##1 cap && !restart |=>
		pix_hold_reg.comp_hi == CVP_COMP_Y && pix_hold_reg.comp_lo == CVP_COMP_Y)
		else $error("channel phase wrong after line start");
	gate_block_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		!pcfg_reg.field_sel && !wf_s |=> $stable(pix_tgl_reg))
		else $error("sample stored while write gate low");
	field_tag_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && frame_start && pcfg_reg.field_sel |=> pix_hold_reg.field == $past(wf_s))
		else $error("field tag differs from field pin");
	two_field_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		pcfg_reg.enable && frame_start && !pcfg_reg.field_sel && pcfg_reg.two_field
		|=> field_reg != $past(field_reg))
		else $error("field not toggled at frame start");
	slave_drive_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		!pcfg_reg.master |-> !line_sync_oe && !frame_sync_oe && !line_sync_out)
		else $error("sync pins driven in slave mode");
	line_wrap_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		run_master && $stable(pcfg_reg) && h_cnt_reg == pcfg_reg.line_len - 16'h0001
		|=> line_sync_out ##1 !line_sync_out)
		else $error("line sync not one pixel at line end");
	frame_wrap_a: assert property (@(posedge pixel_clk) disable iff (prst_reg)
		run_master && $stable(pcfg_reg) && h_cnt_reg == pcfg_reg.line_len - 16'h0001
		&& v_cnt_reg == pcfg_reg.frame_len - 16'h0001 |=> frame_sync_out && line_sync_out)
		else $error("frame sync missing after last line");
	reg_read_a: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == `CVP_OFS_LINE_LEN |=> reg_rdata == {16'h0000, $past(cfg_reg.line_len)})
		else $error("line length readback wrong");
	pix_xfer_a: assert property (@(posedge clk) disable iff (rst)
		new_pix |=> pix_valid && pix_out == $past(pix_hold_reg))
		else $error("pixel word not transferred");

	dual_cap_c: cover property (@(posedge pixel_clk) disable iff (prst_reg)
		cap && pcfg_reg.mode == CVP_YCC8);
	master_frame_c: cover property (@(posedge pixel_clk) disable iff (prst_reg)
		run_master && frame_start);
	field_flip_c: cover property (@(posedge pixel_clk) disable iff (prst_reg)
		frame_start && field_now != field_reg);
	cfg_launch_c: cover property (@(posedge clk) disable iff (rst) launch);

endmodule
`default_nettype wire

// File: test/cvp_sensor_model.sv
// Sensor front end model: pixel clock, data lines, syncs and gate/field pin
`default_nettype none
module cvp_sensor_model (
	output logic       pixel_clk,
	output logic [7:0] lower_video_data,
	output logic [7:0] upper_video_data,
	output logic       write_gate_or_field_id,
	output logic       frame_sync_drv,
	output logic       line_sync_drv
);
	timeunit 1ns;
	timeprecision 1ps;

	// Runs free, also in reset: the device times its master syncs from it
	initial begin
		pixel_clk = 1'b0;
		lower_video_data = 8'h00;
		upper_video_data = 8'h00;
		write_gate_or_field_id = 1'b0;
		frame_sync_drv = 1'b0;
		line_sync_drv = 1'b0;
		#7;
		forever #24 pixel_clk = ~pixel_clk;
	end

	// One pixel: pins move just after a rising edge and hold a whole period
	task automatic px(
		input logic [7:0] lo,
		input logic [7:0] up,
		input logic       ls,
		input logic       fs,
		input logic       wg
	);
		@(posedge pixel_clk);
		lower_video_data <= lo;
		upper_video_data <= up;
		line_sync_drv <= ls;
		frame_sync_drv <= fs;
		write_gate_or_field_id <= wg;
	endtask
endmodule
`default_nettype wire

// File: test/cvp_capture_bench.sv
// Self-checking bench of the video capture port
`include "cvp_map.svh"
`default_nettype none
module cvp_capture_bench
	import cvp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(what, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			fails++; \
			$display("Error %s expected %h seen %h", what, exp, got); \
		end \
	end

	logic        clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        pix_valid;
	cvp_pix_t    pix_out;
	logic        pixel_clk;
	logic [7:0]  lo_d;
	logic [7:0]  up_d;
	logic        wg;
	logic        fs_drv;
	logic        ls_drv;
	logic        fs_out;
	logic        fs_oe;
	logic        ls_out;
	logic        ls_oe;
	logic        fs_pin;
	logic        ls_pin;
	cvp_mode_t   mode;
	logic        fsel;
	logic        two;
	logic        field;
	logic [15:0] last_d;
	logic [31:0] rd;
	cvp_pix_t    exp_s;
	cvp_pix_t    exp_q[$];
	int          ph;
	int          frames;
	int          n;
	int          lc;
	int          fc;
	int          fails;
	int          cmp_count;
	int          cycles;

	// Shared pins: whoever has the output enable owns the wire
	assign fs_pin = fs_oe ? fs_out : fs_drv;
	assign ls_pin = ls_oe ? ls_out : ls_drv;

	cvp_sensor_model model (
		.pixel_clk              (pixel_clk),
		.lower_video_data       (lo_d),
		.upper_video_data       (up_d),
		.write_gate_or_field_id (wg),
		.frame_sync_drv         (fs_drv),
		.line_sync_drv          (ls_drv)
	);

	cvp_capture uut (
		.clk                    (clk),
		.rst                    (rst),
		.pixel_clk              (pixel_clk),
		.lower_video_data       (lo_d),
		.upper_video_data       (up_d),
		.write_gate_or_field_id (wg),
		.frame_sync_in          (fs_pin),
		.frame_sync_out         (fs_out),
		.frame_sync_oe          (fs_oe),
		.line_sync_in           (ls_pin),
		.line_sync_out          (ls_out),
		.line_sync_oe           (ls_oe),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.pix_valid              (pix_valid),
		.pix_out                (pix_out)
	);

	always #2 clk = ~clk;

	task automatic stop_test();
		if (fails == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles > 30000) begin
			fails++;
			stop_test();
		end
	end

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask

	function automatic cvp_pix_t exp_pix(input logic [7:0] lo, up, input logic sl, sf);
		cvp_pix_t e;
		e.data = {up, lo};
		e.comp_lo = CVP_COMP_Y;
		e.comp_hi = ph[0] ? CVP_COMP_CR : CVP_COMP_CB;
		if (mode == CVP_YCC8) begin
			e.comp_lo = ph[0] ? CVP_COMP_Y : (ph[1] ? CVP_COMP_CR : CVP_COMP_CB);
			e.comp_hi = e.comp_lo;
		end else if (mode == CVP_RAW14) begin
			e.data = {2'b00, up[5:0], lo};
			e.comp_lo = CVP_COMP_RAW;
			e.comp_hi = CVP_COMP_RAW;
		end
		e.field = field;
		e.sol = sl;
		e.sof = sf;
		return e;
	endfunction

	task automatic idle(input int k);
		repeat (k) model.px(8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
	endtask

	// Idle pixels carry zero data and are not predicted; the monitor skips them
	task automatic send(input logic [7:0] lo, up, input logic ls, fs, g);
		model.px(lo, up, ls, fs, g);
		if (ls) ph = 0;
		if (fs) field = fsel ? g : (two & ~field);
		if ((fsel || g) && lo != 8'h00) begin
			exp_q.push_back(exp_pix(lo, up, ls, fs));
			last_d = exp_q[$].data;
			frames += fs;
			ph++;
		end
	endtask

	task automatic frame(input int lines, input logic fid, input logic rg);
		logic g;
		for (int l = 0; l < lines; l++) begin
			for (int p = 0; p < 6; p++) begin
				g = fsel ? fid : (p == 0 || !rg || $urandom_range(1) == 1);
				send(8'($urandom()) | 8'h01, 8'($urandom()), p == 0, l == 0 && p == 0, g);
			end
			model.px(8'h00, 8'h00, 1'b0, 1'b0, fsel & fid);
		end
	endtask

	// Config crosses to the pixel side in a few pixel clocks; wait it out idle
	task automatic setup(input cvp_mode_t md, input logic fsl, tw, ms);
		reg_write(`CVP_OFS_CTRL, {26'h0, tw, fsl, ms, md, 1'b1});
		mode = md;
		fsel = fsl;
		two = tw;
		idle(12);
	endtask

	always @(posedge clk) begin
		if (pix_valid === 1'b1 && pix_out.data !== 16'h0000) begin
			exp_s = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
			`CHK("pix_out", exp_s, pix_out)
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mode = CVP_RAW14;
		fsel = 1'b0;
		two = 1'b0;
		field = 1'b0;
		last_d = 16'h0;
		ph = 0;
		frames = 0;
		fails = 0;
		cmp_count = 0;
		cycles = 0;
		void'($urandom(32'hAAAC5FED));
		repeat (4) @(posedge pixel_clk);
		@(posedge clk);
		rst <= 1'b0;
		idle(4);
		reg_read(`CVP_OFS_LINE_LEN, rd);
		`CHK("line_len", {16'h0000, `CVP_RST_LINE_LEN}, rd)
		reg_read(`CVP_OFS_FRAME_LEN, rd);
		`CHK("frame_len", {16'h0000, `CVP_RST_FRAME_LEN}, rd)
		reg_write(8'h14, 32'hFFFFFFFF);
		reg_read(8'h14, rd);
		`CHK("unmapped", 32'h0, rd)
		`CHK("sync_oe", 2'b00, {fs_oe, ls_oe})
		setup(CVP_YCC16, 1'b0, 1'b1, 1'b0);
		frame(2, 1'b0, 1'b0);
		frame(2, 1'b0, 1'b0);
		setup(CVP_RAW14, 1'b1, 1'b0, 1'b0);
		frame(2, 1'b1, 1'b0);
		frame(3, 1'b0, 1'b0);
		setup(CVP_YCC8, 1'b0, 1'b0, 1'b0);
		frame(3, 1'b1, 1'b1);
		frame(2, 1'b0, 1'b1);
		idle(8);
		reg_read(`CVP_OFS_PIXEL, rd);
		`CHK("pixel", last_d, rd[15:0])
		reg_read(`CVP_OFS_STATUS, rd);
		`CHK("frame_count", frames[15:0], rd[31:16])
		`CHK("status_low", {1'b0, field, 1'b0}, rd[2:0])
		`CHK("pending", 0, exp_q.size())
		reg_write(`CVP_OFS_LINE_LEN, 32'h5);
		reg_write(`CVP_OFS_FRAME_LEN, 32'h3);
		setup(CVP_RAW14, 1'b0, 1'b0, 1'b1);
		`CHK("sync_oe", 2'b11, {fs_oe, ls_oe})
		n = 0;
		while (fs_out !== 1'b0 && n < 20) begin
			@(negedge pixel_clk);
			n++;
		end
		while (fs_out !== 1'b1 && n < 40) begin
			@(negedge pixel_clk);
			n++;
		end
		lc = 0;
		fc = 0;
		repeat (45) begin
			lc += (ls_out === 1'b1);
			fc += (fs_out === 1'b1);
			@(negedge pixel_clk);
		end
		`CHK("line_syncs", 9, lc)
		`CHK("frame_sync_len", 15, fc)
		stop_test();
	end
endmodule
`default_nettype wire
